// ===== hw/igld_top.sv
// Behaviour
// RULE1: per-channel gain -64 to +31.5 dB
// RULE2: code 0x00=-64 dB, 0x80=0 dB, reset 0x80
// RULE3: per-channel mute bit, muted after reset
// RULE4: gain and mute pending until commit
// RULE5: ramp up at rise, down at fall rate
// RULE6: ramp rate codes 0..30 ms, reset 010
// RULE7: software keeps rates fixed during ramps
// RULE8: ramps move in eighth-dB steps
// RULE9: -6 dBFS input at 0 dB is full scale
// RULE10: per-channel detect enable, reset off
// RULE11: shared 5-bit threshold, reset 0x00
// RULE12: detecting channel silent below, opens at once
// RULE13: recloses after quiet longer than hold
// RULE14: hold code table, reset 0001
// RULE15: software keeps detecting channels unmuted
// RULE16: event is OR of all channels
// RULE17: event rearms only when all quiet
// RULE18: combined status drives a pin
// RULE19: software uses supported rates only
// RULE20: shared cutoff field, reset 010
// RULE21: commit bit reads zero, no state
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module igld_top #(
  parameter int unsigned MS_CYCLES = igld_pkg::MS_CYCLES_DEF
) (
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  input  wire logic [15:0]         addr,
  input  wire logic [31:0]         wr_data,
  input  wire logic                wr_en,
  input  wire logic                rd_en,
  output logic      [31:0]         rd_data,
  input  wire logic [3:0][23:0]    in_samples,
  input  wire logic [3:0]          in_valid,
  output logic      [3:0][23:0]    out_samples,
  output logic      [3:0]          out_valid,
  output logic                     level_event,
  output logic                     level_status,
  output logic      [2:0]          highpass_cutoff,
  output logic      [3:0]          hpf_enable
);
  localparam int unsigned NCH = igld_pkg::NCH;

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [NCH-1:0][7:0]  pend_gain;
  logic [NCH-1:0]       pend_mute;
  logic [NCH-1:0][7:0]  eff_gain;
  logic [NCH-1:0]       eff_mute;
  logic [NCH-1:0]       detect_on;
  logic [4:0]           level_threshold;
  logic [3:0]           quiet_hold_time;
  logic [2:0]           rise_ramp_rate;
  logic [2:0]           fall_ramp_rate;
  logic                 commit_hit;

  // ---------------------------------------------------------------
  // Datapath state
  // ---------------------------------------------------------------
  logic [NCH-1:0][9:0]  cur_gain;
  logic [NCH-1:0][9:0]  tgt_gain;
  logic [NCH-1:0]       above;
  logic [NCH-1:0]       detect;
  logic [NCH-1:0]       chan_det;
  logic [NCH-1:0]       ramping;
  logic [31:0]          ms_cnt;
  logic                 ms_tick;
  logic [31:0]          rise_cnt;
  logic [31:0]          fall_cnt;
  logic [31:0]          rise_lim;
  logic [31:0]          fall_lim;
  logic                 rise_tick;
  logic                 fall_tick;
  logic                 armed;
  logic [23:0]          thr_mag;
  logic [NCH-1:0]       gain_valid;
  logic [NCH-1:0][23:0] gain_sample;
  logic                 loud_any;

  igld_chan_if ch_if [NCH] ();

  // Commit strobe acts on the written value only, nothing is stored [RULE21]
  assign commit_hit = wr_en && addr == igld_pkg::COMMIT_OFS && wr_data[igld_pkg::COMMIT_BIT];

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  // Per-channel pending gain, mute and enables
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pend_gain  <= {NCH{igld_pkg::GAIN_RST}};            // [RULE2]
      pend_mute  <= '1;                                   // [RULE3]
      detect_on  <= '0;                                   // [RULE10]
      hpf_enable <= '0;
    end else if (wr_en) begin
      for (int i = 0; i < NCH; i++) begin
        if (addr == igld_pkg::GAIN_OFS[i]) begin
          pend_gain[i] <= wr_data[igld_pkg::GAIN_LSB +: 8];
          pend_mute[i] <= wr_data[igld_pkg::MUTE_BIT];
        end
        if (addr == igld_pkg::CFG_OFS[i]) begin
          detect_on[i]  <= wr_data[igld_pkg::DET_BIT];
          hpf_enable[i] <= wr_data[igld_pkg::HPFEN_BIT];
        end
      end
    end
  end

  // Effective settings move together on commit
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      eff_gain <= {NCH{igld_pkg::GAIN_RST}};
      eff_mute <= '1;                                      // [RULE3]
    end else if (commit_hit) begin
      eff_gain <= pend_gain;                               // [RULE4]
      eff_mute <= pend_mute;
    end
  end

  // Shared fields
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      level_threshold <= igld_pkg::THR_RST;                // [RULE11]
      quiet_hold_time <= igld_pkg::HOLD_RST;               // [RULE14]
      highpass_cutoff <= igld_pkg::CUT_RST;                // [RULE20]
      rise_ramp_rate  <= igld_pkg::RAMP_RST;               // [RULE6]
      fall_ramp_rate  <= igld_pkg::RAMP_RST;
    end else if (wr_en) begin
      if (addr == igld_pkg::THR_OFS) begin
        level_threshold <= wr_data[igld_pkg::THR_LSB +: 5];
        quiet_hold_time <= wr_data[3:0];
      end
      if (addr == igld_pkg::HPF_OFS) highpass_cutoff <= wr_data[2:0];
      if (addr == igld_pkg::RAMP_OFS) begin
        rise_ramp_rate <= wr_data[2:0];
        fall_ramp_rate <= wr_data[igld_pkg::FALL_LSB +: 3];
      end
    end
  end

  // ---------------------------------------------------------------
  // Register reads
  // ---------------------------------------------------------------
  // Read data one cycle after the strobe; unmapped and commit read zero
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= '0;                                       // [RULE21]
      for (int i = 0; i < NCH; i++) begin
        if (addr == igld_pkg::GAIN_OFS[i])
          rd_data <= {3'h0, pend_mute[i], 4'h0, pend_gain[i], 16'h0000};
        if (addr == igld_pkg::CFG_OFS[i])
          rd_data <= {29'h0, hpf_enable[i], detect_on[i], 1'b0};
      end
      if (addr == igld_pkg::THR_OFS)
        rd_data <= {23'h0, level_threshold, quiet_hold_time};
      if (addr == igld_pkg::HPF_OFS)
        rd_data <= {29'h0, highpass_cutoff};
      if (addr == igld_pkg::RAMP_OFS)
        rd_data <= {25'h0, fall_ramp_rate, 1'b0, rise_ramp_rate};
      if (addr == igld_pkg::STAT_OFS)
        rd_data <= {20'h0, ramping, chan_det, 3'h0, level_status};
    end
  end

  // ---------------------------------------------------------------
  // Ramp timing
  // ---------------------------------------------------------------
  // Cycles per eighth-dB step, never below one
  always_comb begin
    rise_lim = 32'(igld_pkg::igld_ramp_ms(rise_ramp_rate)) * MS_CYCLES / igld_pkg::RAMP_SPAN;
    fall_lim = 32'(igld_pkg::igld_ramp_ms(fall_ramp_rate)) * MS_CYCLES / igld_pkg::RAMP_SPAN;
    if (rise_lim == 32'h0) rise_lim = 32'h1;
    if (fall_lim == 32'h0) fall_lim = 32'h1;
  end

  assign rise_tick = (rise_cnt + 32'h1 >= rise_lim);
  assign fall_tick = (fall_cnt + 32'h1 >= fall_lim);
  assign ms_tick   = (ms_cnt + 32'h1 >= MS_CYCLES);

  // Free-running step and millisecond prescalers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rise_cnt <= '0;
      fall_cnt <= '0;
      ms_cnt   <= '0;
    end else begin
      rise_cnt <= rise_tick ? 32'h0 : rise_cnt + 32'h1;
      fall_cnt <= fall_tick ? 32'h0 : fall_cnt + 32'h1;
      ms_cnt   <= ms_tick ? 32'h0 : ms_cnt + 32'h1;
    end
  end

  // ---------------------------------------------------------------
  // Gain ramps and gain stages
  // ---------------------------------------------------------------
  // Target in eighth-dB; mute ramps to the bottom then silences
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      tgt_gain[i] = eff_mute[i] ? 10'h000 :
                    {(eff_gain[i] > igld_pkg::GAIN_MAX) ? igld_pkg::GAIN_MAX : eff_gain[i],
                     2'h0};                                // [RULE2] [RULE8]
      ramping[i]  = (cur_gain[i] != tgt_gain[i]);
    end
  end

  // One eighth-dB step per tick of the matching rate; rate code 0 jumps straight to the target
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cur_gain <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (cur_gain[i] < tgt_gain[i]) begin
          if (rise_ramp_rate == 3'h0)
            cur_gain[i] <= tgt_gain[i];
          else if (rise_tick)
            cur_gain[i] <= cur_gain[i] + 10'h001;          // [RULE5] [RULE8]
        end else if (cur_gain[i] > tgt_gain[i]) begin
          if (fall_ramp_rate == 3'h0)
            cur_gain[i] <= tgt_gain[i];
          else if (fall_tick)
            cur_gain[i] <= cur_gain[i] - 10'h001;          // [RULE5]
        end
      end
    end
  end

  assign thr_mag = igld_pkg::igld_thr(level_threshold);

  for (genvar g = 0; g < NCH; g++) begin : g_chan
    assign ch_if[g].in_sample = in_samples[g];
    assign ch_if[g].in_valid  = in_valid[g];
    assign ch_if[g].gain_idx  = cur_gain[g];
    assign ch_if[g].silent    = eff_mute[g] && cur_gain[g] == 10'h000;  // [RULE3]

    // Gain-stage results as plain arrays, so loops can index them
    assign gain_valid[g]  = ch_if[g].out_valid;
    assign gain_sample[g] = ch_if[g].out_sample;

    // Level is measured after gain and mute
    assign above[g] = gain_valid[g] && igld_pkg::igld_mag(gain_sample[g]) > thr_mag;
    assign chan_det[g] = detect_on[g] && (detect[g] || above[g]);

    igld_gain u_gain (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .chan    (ch_if[g])
    );

    igld_hold u_hold (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .enable  (detect_on[g]),
      .above   (above[g]),
      .ms_tick (ms_tick),
      .hold_ms (igld_pkg::igld_hold_ms(quiet_hold_time)),   // [RULE14]
      .detect  (detect[g])
    );
  end

  // ---------------------------------------------------------------
  // Output gating and detection events
  // ---------------------------------------------------------------
  // Detecting channels pass only while open; a loud sample opens at once
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      out_samples <= '0;
      out_valid   <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        out_valid[i] <= gain_valid[i];
        if (gain_valid[i])
          out_samples[i] <= (detect_on[i] && !chan_det[i]) ? 24'h000000
                                                           : gain_sample[i]; // [RULE12]
      end
    end
  end

  // Any detecting channel loud in this cycle
  assign loud_any = |(above & detect_on);

  // One OR-ed event, rearmed once every channel is quiet
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      armed        <= 1'b1;
      level_event  <= 1'b0;
      level_status <= 1'b0;
    end else begin
      level_status <= |chan_det;                                 // [RULE18]
      level_event  <= armed && loud_any;                         // [RULE16]
      if (armed && loud_any)
        armed <= 1'b0;
      else if (!(|chan_det))
        armed <= 1'b1;                                           // [RULE17]
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  commit_reads_zero_a: assert property ( // [RULE21]
    (rd_en && addr == igld_pkg::COMMIT_OFS) |=> rd_data == 32'h0)
    else $error("commit register did not read zero");

  pending_held_a: assert property ( // [RULE4]
    !commit_hit |=> eff_gain == $past(eff_gain) && eff_mute == $past(eff_mute))
    else $error("gain or mute changed without commit");

  reset_muted_a: assert property ( // [RULE3]
    !$past(rst_n) |-> eff_mute == 4'hf && pend_gain[0] == igld_pkg::GAIN_RST)
    else $error("channels not muted after reset");

  ramp_step_a: assert property ( // [RULE8]
    (rise_ramp_rate != 3'h0 && fall_ramp_rate != 3'h0) |=>
      (cur_gain[0] == $past(cur_gain[0]) || cur_gain[0] == $past(cur_gain[0]) + 10'h001 ||
       cur_gain[0] == $past(cur_gain[0]) - 10'h001))
    else $error("ramp moved more than one step");

  ramp_rise_a: assert property ( // [RULE5]
    (rise_ramp_rate != 3'h0 && rise_tick && cur_gain[0] < tgt_gain[0]) |=>
      cur_gain[0] == $past(cur_gain[0]) + 10'h001)
    else $error("rise ramp missed its step");

  gate_zero_a: assert property ( // [RULE12]
    (ch_if[0].out_valid && detect_on[0] && !chan_det[0]) |=> out_samples[0] == 24'h000000)
    else $error("quiet detecting channel not silenced");

  event_cause_a: assert property ( // [RULE16] [RULE17]
    level_event |-> $past(armed) && $past(loud_any) && !armed)
    else $error("level event without armed loud channel");

  event_rearm_a: assert property ( // [RULE17]
    (!armed && !(|chan_det)) |=> armed)
    else $error("level event did not rearm when all quiet");

  status_pin_a: assert property ( // [RULE18]
    level_event |-> level_status)
    else $error("event fired without status");

  cutoff_reset_a: assert property ( // [RULE20]
    !$past(rst_n) |-> highpass_cutoff == igld_pkg::CUT_RST &&
      rise_ramp_rate == igld_pkg::RAMP_RST)
    else $error("cutoff or ramp reset value wrong");

endmodule // igld_top
`default_nettype wire

// ===== hw/igld_pkg.sv
`default_nettype none
package igld_pkg;

  // ---------------------------------------------------------------
  // Sizes and timing
  // ---------------------------------------------------------------
  localparam int unsigned REF_CLK_HZ    = 125_000_000;
  localparam int unsigned MS_PER_S      = 1000;
  localparam int unsigned MS_CYCLES_DEF = REF_CLK_HZ / MS_PER_S;
  localparam int unsigned NCH           = 4;
  localparam int unsigned SW            = 24;
  localparam int unsigned GW            = 10;
  localparam int unsigned AW            = 16;
  localparam int unsigned DW            = 32;
  localparam int unsigned RAMP_SPAN     = 48;   // Eighth-dB steps per rate unit (6 dB)

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [AW-1:0] COMMIT_OFS = 16'h4014;
  localparam logic [AW-1:0] THR_OFS    = 16'h4240;
  localparam logic [AW-1:0] HPF_OFS    = 16'h4244;
  localparam logic [AW-1:0] RAMP_OFS   = 16'h4248;
  localparam logic [AW-1:0] STAT_OFS   = 16'h4250;
  localparam logic [AW-1:0] CFG_OFS  [NCH] = '{16'h4024, 16'h4044, 16'h4064, 16'h4084};
  localparam logic [AW-1:0] GAIN_OFS [NCH] = '{16'h4028, 16'h4048, 16'h4068, 16'h4088};

  localparam int unsigned COMMIT_BIT = 29;
  localparam int unsigned DET_BIT    = 1;
  localparam int unsigned HPFEN_BIT  = 2;
  localparam int unsigned MUTE_BIT   = 28;
  localparam int unsigned GAIN_LSB   = 16;
  localparam int unsigned THR_LSB    = 4;
  localparam int unsigned FALL_LSB   = 4;
  localparam int unsigned STAT_DET_LSB  = 4;
  localparam int unsigned STAT_RAMP_LSB = 8;

  localparam logic [7:0] GAIN_RST  = 8'h80;
  localparam logic [7:0] GAIN_MAX  = 8'hbf;
  localparam logic [4:0] THR_RST   = 5'h00;
  localparam logic [4:0] THR_MAX   = 5'h0d;
  localparam logic [3:0] HOLD_RST  = 4'h1;
  localparam logic [2:0] CUT_RST   = 3'h2;
  localparam logic [2:0] RAMP_RST  = 3'h2;
  localparam logic [GW-1:0] GAIN_IDX_OFS = 10'h010;  // Puts 0 dB on an octave boundary
  localparam logic [SW-1:0] POS_MAX = 24'h7fffff;
  localparam logic [SW-1:0] NEG_MIN = 24'h800000;

  typedef logic [SW-1:0] igld_sample_t;

  // Saturate a wide product to one sample
  function automatic igld_sample_t igld_sat(input logic signed [41:0] v);
    if (v > $signed({18'h00000, POS_MAX}))
      return POS_MAX;
    else if (v < $signed({18'h3ffff, NEG_MIN}))
      return NEG_MIN;
    else
      return v[SW-1:0];
  endfunction

  // Magnitude of a sample, full scale clipped
  function automatic igld_sample_t igld_mag(input igld_sample_t s);
    return s[SW-1] ? ((s == NEG_MIN) ? POS_MAX : igld_sample_t'(-s)) : s;
  endfunction

  // Detection threshold as a sample magnitude
  function automatic igld_sample_t igld_thr(input logic [4:0] c);
    case (c)
      5'h00:   return 24'h040000;
      5'h01:   return 24'h020000;
      5'h02:   return 24'h010000;
      5'h03:   return 24'h008000;
      5'h04:   return 24'h005f97;
      5'h05:   return 24'h004000;
      5'h06:   return 24'h002fcb;
      5'h07:   return 24'h002000;
      5'h08:   return 24'h001000;
      5'h09:   return 24'h000bf2;
      5'h0a:   return 24'h000800;
      5'h0b:   return 24'h0005f9;
      5'h0c:   return 24'h0003fc;
      default: return 24'h0002fd;
    endcase
  endfunction

  // Quiet hold time in ms
  function automatic logic [9:0] igld_hold_ms(input logic [3:0] c);
    case (c)
      4'h9:    return 10'h024;
      4'ha:    return 10'h028;
      4'hb:    return 10'h030;
      4'hc:    return 10'h060;
      4'hd:    return 10'h0c0;
      4'he:    return 10'h180;
      4'hf:    return 10'h300;
      4'h0:    return 10'h004;
      default: return {4'h0, c, 2'h0};
    endcase
  endfunction

  // Ramp rate in ms per 6 dB
  function automatic logic [4:0] igld_ramp_ms(input logic [2:0] c);
    case (c)
      3'h2:    return 5'h01;
      3'h3:    return 5'h02;
      3'h4:    return 5'h04;
      3'h5:    return 5'h08;
      3'h6:    return 5'h0f;
      3'h7:    return 5'h1e;
      default: return 5'h00;
    endcase
  endfunction

endpackage
`default_nettype wire

// ===== hw/igld_chan_if.sv
`timescale 1ns/1ns
`default_nettype none
interface igld_chan_if;
  logic [23:0] in_sample;
  logic        in_valid;
  logic [9:0]  gain_idx;
  logic        silent;
  logic [23:0] out_sample;
  logic        out_valid;
  modport gain (input in_sample, in_valid, gain_idx, silent, output out_sample, out_valid);
  modport core (output in_sample, in_valid, gain_idx, silent, input out_sample, out_valid);
endinterface
`default_nettype wire

// ===== hw/igld_gain.sv
`timescale 1ns/1ns
`default_nettype none
module igld_gain (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  igld_chan_if.gain chan
);
  logic [10:0]        t;
  logic [4:0]         oct;
  logic [5:0]         frac;
  logic [16:0]        mant;
  logic signed [41:0] prod;
  logic [5:0]         shamt;

  // Eighth-dB index to linear: octave shift and linear mantissa
  always_comb begin
    t     = {1'b0, chan.gain_idx} + {1'b0, igld_pkg::GAIN_IDX_OFS};
    oct   = 5'(t / 11'(igld_pkg::RAMP_SPAN));
    frac  = 6'(t % 11'(igld_pkg::RAMP_SPAN));
    mant  = 17'h08000 + 17'(frac) * 17'h002ab;
    prod  = $signed(chan.in_sample) * $signed({1'b0, mant});
    shamt = 6'h19 - {1'b0, oct};   // Extra doubling lifts -6 dBFS to full scale [RULE9]
  end

  // Registered gain stage
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      chan.out_valid  <= 1'b0;
      chan.out_sample <= '0;
    end else begin
      chan.out_valid <= chan.in_valid;
      if (chan.in_valid) begin
        chan.out_sample <= chan.silent ? '0 : igld_pkg::igld_sat(prod >>> shamt); // [RULE1]
      end
    end
  end
endmodule // igld_gain
`default_nettype wire

// ===== hw/igld_hold.sv
`timescale 1ns/1ns
`default_nettype none
module igld_hold (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       enable,
  input  wire logic       above,
  input  wire logic       ms_tick,
  input  wire logic [9:0] hold_ms,
  output logic            detect
);
  typedef enum logic {IGLD_GATED = 1'b0, IGLD_OPEN = 1'b1} igld_hold_t;
  igld_hold_t state;
  logic [9:0] quiet_ms;

  // Open on any loud sample, close after a long enough quiet spell
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state    <= IGLD_GATED;
      quiet_ms <= '0;
    end else begin
      case (state)
        IGLD_GATED: begin
          quiet_ms <= '0;
          if (enable && above) state <= IGLD_OPEN;
        end
        IGLD_OPEN: begin
          if (!enable) begin
            state <= IGLD_GATED;
          end else if (above) begin
            quiet_ms <= '0;
          end else if (quiet_ms > hold_ms) begin
            state <= IGLD_GATED;                      // [RULE13]
          end else if (ms_tick) begin
            quiet_ms <= quiet_ms + 10'h001;
          end
        end
        default: state <= IGLD_GATED;
      endcase
    end
  end

  assign detect = (state == IGLD_OPEN);

  hold_close_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE13]
    (state == IGLD_OPEN && enable && !above && quiet_ms > hold_ms) |=> state == IGLD_GATED)
    else $error("quiet hold did not close the channel");
endmodule // igld_hold
`default_nettype wire

// ===== dv/igld_src_model.sv
`timescale 1ns/1ns
`default_nettype none
module igld_src_model (
  input  wire logic             clk,
  input  wire logic [23:0]      amp,
  output var  logic [3:0][23:0] samples,
  output var  logic [3:0]       valid
);
  logic [1:0] div;
  // ----------------------------------------
  // Converter stand-in: DC level on all channels
  // ----------------------------------------
  initial begin
    div = 2'h0;
    valid = 4'h0;
    samples = '0;
  end
  // One sample every four clocks, a supported rate
  always @(posedge clk) begin
    div <= div + 2'h1;
    valid <= {4{div == 2'h3}};
    samples <= {4{amp}};
  end
endmodule // igld_src_model
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic             ref_clk = 1'b0;
  logic             rst_n = 1'b0;
  logic             wr_en = 1'b0;
  logic             rd_en = 1'b0;
  logic [15:0]      addr = 16'h0000;
  logic [31:0]      wr_data = 32'h0, rd_data;
  logic [23:0]      amp = 24'h000000;
  logic [3:0][23:0] in_samples, out_samples;
  logic [3:0]       in_valid, out_valid, hpf_enable;
  logic             level_event, level_status;
  logic [2:0]       highpass_cutoff;
  int               err_total = 0, samples_checked = 0, cyc = 0, evt = 0;
  localparam logic [15:0] STAT = 16'h4250;

  // Clock, 8 ns period
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  igld_src_model i_src (.clk(ref_clk), .amp, .samples(in_samples), .valid(in_valid));
  igld_top #(.MS_CYCLES(96)) i_dut (.ref_clk, .rst_n, .addr, .wr_data, .wr_en, .rd_en,
    .rd_data, .in_samples, .in_valid, .out_samples, .out_valid, .level_event,
    .level_status, .highpass_cutoff, .hpf_enable);

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    chk("rd_data", exp, rd_data);
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk_out(input logic [23:0] exp);
    for (int k = 0; k < 20 && out_valid[0] !== 1'b1; k++) begin
      waitc(1);
    end
    chk("out_sample", {8'h0, exp}, {8'h0, out_samples[0]});
  endtask
  task automatic commit();
    wr(16'h4014, 32'h2000_0000);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    for (int i = 0; i < 4; i++) begin
      rd(igld_pkg::GAIN_OFS[i], 32'h1080_0000);
      rd(igld_pkg::CFG_OFS[i], 32'h0);
    end
    rd(16'h4240, 32'h1);
    rd(16'h4244, 32'h2);
    rd(16'h4248, 32'h22);
    rd(16'h4300, 32'h0);
    wr(16'h4244, 32'h3);
    waitc(2);
    chk("cutoff", 32'h3, {29'h0, highpass_cutoff});
    $display("reset values done");
  endtask
  task automatic t_commit();
    wr(16'h4248, 32'h0);
    amp <= 24'h200000;
    wr(igld_pkg::GAIN_OFS[0], 32'h0080_0000);
    waitc(20);
    chk_out(24'h0);
    commit();
    waitc(20);
    chk_out(24'h400000);
    chk("muted ch1", 32'h0, {8'h0, out_samples[1]});
    rd(16'h4014, 32'h0);
    $display("commit done");
  endtask
  task automatic t_ramp();
    wr(16'h4248, 32'h22);
    wr(igld_pkg::GAIN_OFS[0], 32'h008c_0000);
    commit();
    rd(STAT, 32'h100);
    waitc(70);
    rd(STAT, 32'h100);
    waitc(40);
    rd(STAT, 32'h0);
    chk_out(24'h7fffff);
    wr(16'h4248, 32'h32);
    wr(igld_pkg::GAIN_OFS[0], 32'h108c_0000);
    commit();
    waitc(1500);
    rd(STAT, 32'h100);
    waitc(900);
    rd(STAT, 32'h0);
    chk_out(24'h0);
    $display("ramp done");
  endtask
  task automatic t_detect();
    int n;
    wr(16'h4248, 32'h0);
    wr(igld_pkg::GAIN_OFS[0], 32'h0080_0000);
    commit();
    amp <= 24'h001000;
    wr(igld_pkg::CFG_OFS[0], 32'h6);
    waitc(20);
    chk_out(24'h0);
    chk("hpf_en", 32'h1, {28'h0, hpf_enable});
    n = evt;
    amp <= 24'h100000;
    waitc(12);
    chk_out(24'h200000);
    chk("status", 32'h1, {31'h0, level_status});
    chk("events", 32'(n + 1), evt);
    amp <= 24'h001000;
    waitc(300);
    chk("status", 32'h1, {31'h0, level_status});
    waitc(600);
    chk("status", 32'h0, {31'h0, level_status});
    chk_out(24'h0);
    amp <= 24'h100000;
    waitc(12);
    chk("events", 32'(n + 2), evt);
    $display("detect done");
  endtask

  // Event counter and run ceiling
  always @(posedge ref_clk) begin
    cyc++;
    if (level_event === 1'b1) begin
      evt++;
    end
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_commit();
    t_ramp();
    t_detect();
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
